// *** hw/lmb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lmb_cfg.svh"
module lmb_top #(
    parameter int DEPTH = `LMB_DEPTH,
    parameter int AW = 7
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [1:0] ctl_id,
    input wire logic ctl_req,
    input wire logic ctl_we,
    input wire logic ctl_buf,
    input wire lmb_pkg::lmb_byte_t ctl_wdata,
    output logic ctl_gnt,
    output lmb_pkg::lmb_byte_t ctl_rdata,
    output logic ctl_rvalid,
    input wire logic ctl_start,
    input wire logic ctl_tx_done,
    input wire logic ctl_rx_eot,
    output logic tx_buffer_free_flag,
    output logic rx_buffer_pointer_flag
);
    import lmb_pkg::*;

    lmb_state_e st_q;
    lmb_state_e st_d;
    logic [11:0] idx_q;
    logic [1:0] sel_q;
    logic [`LMB_NUM_CTL-1:0] tx_free_q;
    logic [`LMB_NUM_CTL-1:0] rx_ptr_q;
    logic [1:0] valid_q;
    logic [31:0] hrdata_q;
    logic ctl_rvalid_q;
    logic ctl_rbuf_q;
    logic [7:0] ctl_hold_q;

    // address phase decode
    wire logic accept = hsel && htrans[1] && hready;
    wire logic [11:0] a_idx = haddr[`LMB_IDX_MSB:`LMB_IDX_LSB];
    wire logic a_high_ok = (haddr[31:`LMB_IDX_MSB+1] == '0);
    wire logic [11:0] a_idx_ok = a_high_ok ? a_idx : 12'h000;

    // data phase decode
    wire logic hit_buf0 = (idx_q == `LMB_IDX_BUF0);
    wire logic hit_buf1 = (idx_q == `LMB_IDX_BUF1);
    wire logic hit_sel = (idx_q == `LMB_IDX_SEL);
    wire logic hit_stat = (idx_q == `LMB_IDX_STAT);
    wire logic hit_buf = hit_buf0 || hit_buf1;
    wire logic host_buf = hit_buf1;
    wire logic host_wr = (st_q == LMB_ST_WR);
    wire logic host_rd = (st_q == LMB_ST_RD);
    wire logic host_mem = (host_wr || host_rd) && hit_buf;

    // only the chosen controller reaches the buffers
    wire logic ctl_ok = (ctl_id == sel_q);
    wire logic host_clash = host_mem && (host_buf == ctl_buf);
    assign ctl_gnt = ctl_req && ctl_ok && !host_clash;

    wire logic [1:0] wsel = hwdata[1:0];
    wire logic sel_wr = host_wr && hit_sel && (wsel <= `LMB_SEL_MAX);
    wire logic sel_change = sel_wr && (wsel != sel_q);
    wire logic ctl_start_ok = ctl_start && ctl_ok;
    wire logic ctl_done_ok = ctl_tx_done && ctl_ok;
    wire logic ctl_eot_ok = ctl_rx_eot && ctl_ok;

    logic [7:0] mem_rdata [2];
    logic [AW-1:0] ptr [2];
    logic [1:0] set_valid;
    logic [1:0] clr_valid;

    // two identical buffers, one port each
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_buf
            lmb_mem_if #(.AW(AW)) mif (.clk(hclk));
            wire logic host_here = host_mem && (host_buf == 1'(b));
            wire logic ctl_here = ctl_gnt && (ctl_buf == 1'(b));
            wire logic msg_end = (ctl_done_ok || ctl_eot_ok || ctl_start_ok) && (ctl_buf == 1'(b));

            assign mif.en = host_here || ctl_here;
            assign mif.we = host_here ? host_wr : ctl_we;
            assign mif.addr = ptr[b];
            assign mif.wdata = host_here ? hwdata[7:0] : ctl_wdata;
            assign mem_rdata[b] = mif.rdata;
            assign set_valid[b] = mif.en && mif.we;
            assign clr_valid[b] = ctl_done_ok && (ctl_buf == 1'(b));

            lmb_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
                .clk(hclk),
                .rstn(hresetn),
                .port(mif.mem)
            );

            // pointer steps per access, rewinds at ends
            lmb_ptr #(.DEPTH(DEPTH), .AW(AW)) u_ptr (
                .clk(hclk),
                .rstn(hresetn),
                .clr(sel_change || msg_end),
                .inc(mif.en),
                .ptr(ptr[b])
            );
        end
    endgenerate

    // data phase sequencing
    always_comb begin
        st_d = st_q;
        case (st_q)
            LMB_ST_IDLE, LMB_ST_WR, LMB_ST_RDY: begin
                if (accept) begin
                    st_d = hwrite ? LMB_ST_WR : LMB_ST_RD;
                end else begin
                    st_d = LMB_ST_IDLE;
                end
            end
            LMB_ST_RD: begin
                st_d = LMB_ST_CAP;
            end
            LMB_ST_CAP: begin
                st_d = LMB_ST_RDY;
            end
            default: begin
                st_d = LMB_ST_IDLE;
            end
        endcase
    end

    wire logic ready_state = (st_q == LMB_ST_IDLE) || (st_q == LMB_ST_WR) || (st_q == LMB_ST_RDY);
    assign hreadyout = ready_state;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // a sent buffer reads back as zero
    wire logic [7:0] buf_byte = valid_q[host_buf] ? mem_rdata[host_buf] : `LMB_BUF_RST;
    wire logic [7:0] stat_byte = {tx_free_q[sel_q], rx_ptr_q[sel_q], 6'h00};
    wire logic [31:0] rd_mux = hit_buf ? {24'h000000, buf_byte} :
                               hit_sel ? {30'h00000000, sel_q} :
                               hit_stat ? {24'h000000, stat_byte} : 32'h00000000;

    // loading marks valid, sending clears, load wins
    wire logic [1:0] valid_d = (valid_q & ~clr_valid) | set_valid;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= LMB_ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // address phase kept for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= 12'h000;
        end else if (accept && ready_state) begin
            idx_q <= a_idx_ok;
        end
    end

    // read data captured once, held until the next capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (st_q == LMB_ST_CAP) begin
            hrdata_q <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_q <= 2'h0;
        end else begin
            valid_q <= valid_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= `LMB_SEL_RST;
        end else if (sel_wr) begin
            sel_q <= wsel;
        end
    end

    // free flag names next buffer to load
    // pointer flag names buffer holding message
    genvar c;
    generate
        for (c = 0; c < `LMB_NUM_CTL; c++) begin : g_flag
            wire logic mine = (sel_q == 2'(c));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tx_free_q[c] <= 1'b0;
                    rx_ptr_q[c] <= 1'b0;
                end else begin
                    if (mine && ctl_done_ok) begin
                        tx_free_q[c] <= ctl_buf;
                    end
                    if (mine && ctl_eot_ok) begin
                        rx_ptr_q[c] <= ctl_buf;
                    end
                end
            end
        end
    endgenerate

    assign tx_buffer_free_flag = tx_free_q[sel_q];
    assign rx_buffer_pointer_flag = rx_ptr_q[sel_q];

    // controller read return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_rvalid_q <= 1'b0;
            ctl_rbuf_q <= 1'b0;
        end else begin
            ctl_rvalid_q <= ctl_gnt && !ctl_we;
            if (ctl_gnt) begin
                ctl_rbuf_q <= ctl_buf;
            end
        end
    end

    // controller byte stands until its next read, even across host reads
    wire logic [7:0] ctl_byte = mem_rdata[ctl_rbuf_q];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_hold_q <= `LMB_BUF_RST;
        end else if (ctl_rvalid_q) begin
            ctl_hold_q <= ctl_byte;
        end
    end

    assign ctl_rvalid = ctl_rvalid_q;
    assign ctl_rdata = ctl_rvalid_q ? ctl_byte : ctl_hold_q;
endmodule
`default_nettype wire

// *** inc/lmb_cfg.svh ***
`ifndef LMB_CFG_SVH
`define LMB_CFG_SVH
`define LMB_IDX_BUF0 12'h600
`define LMB_IDX_BUF1 12'h700
`define LMB_IDX_SEL 12'h11b
`define LMB_IDX_STAT 12'h120
`define LMB_IDX_LSB 2
`define LMB_IDX_MSB 13
`define LMB_DEPTH 96
`define LMB_BUF_RST 8'h00
`define LMB_SEL_RST 2'h0
`define LMB_SEL_MAX 2'h2
`define LMB_NUM_CTL 3
`define LMB_STAT_TXF_BIT 7
`define LMB_STAT_RXP_BIT 6
`endif

// *** inc/lmb_pkg.sv ***
package lmb_pkg;
    typedef logic [7:0] lmb_byte_t;
    typedef enum logic [4:0] {
        LMB_ST_IDLE = 5'b00001,
        LMB_ST_WR = 5'b00010,
        LMB_ST_RD = 5'b00100,
        LMB_ST_CAP = 5'b01000,
        LMB_ST_RDY = 5'b10000
    } lmb_state_e;
endpackage

// *** inc/lmb_mem_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface lmb_mem_if #(parameter int AW = 7) (input wire logic clk);
    logic en;
    logic we;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** hw/lmb_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lmb_cfg.svh"
module lmb_mem #(
    parameter int DEPTH = `LMB_DEPTH,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic rstn,
    lmb_mem_if.mem port
);
    logic [7:0] arr [DEPTH];
    logic [7:0] rdata_q;

    assign port.rdata = rdata_q;

    always_ff @(posedge clk) begin
        if (port.en && port.we) begin
            arr[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `LMB_BUF_RST;
        end else if (port.en && !port.we) begin
            rdata_q <= arr[port.addr];
        end
    end
endmodule
`default_nettype wire

// *** hw/lmb_ptr.sv ***
`timescale 1ns/100ps
`default_nettype none
module lmb_ptr #(
    parameter int DEPTH = 96,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic inc,
    output logic [AW-1:0] ptr
);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [AW-1:0] ptr_q;
    logic [AW-1:0] ptr_d;

    // auto increment, back to first byte at the end
    assign ptr_d = clr ? '0 : (inc ? ((ptr_q == LAST) ? '0 : ptr_q + 1'b1) : ptr_q);
    assign ptr = ptr_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= '0;
        end else begin
            ptr_q <= ptr_d;
        end
    end
endmodule
`default_nettype wire

// *** test/lmb_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module lmb_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic ctl_req,
    input wire logic ctl_we,
    input wire logic ctl_gnt,
    input wire logic ctl_rvalid
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic tk = hsel & htrans[1] & hready;
    wire logic crd = ctl_req & ctl_gnt & !ctl_we;
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_wait_a: assert property (tk && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    write_wait_a: assert property (tk && hwrite |=> hreadyout)
        else $error("write wait wrong");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    rvalid_after_a: assert property (crd |=> ctl_rvalid)
        else $error("controller read lost");
    rvalid_cause_a: assert property (ctl_rvalid |-> $past(crd))
        else $error("stray read valid");
    grant_req_a: assert property (ctl_gnt |-> ctl_req)
        else $error("grant without request");
    cover property (tk && !hwrite);
    cover property (tk && hwrite);
    cover property (crd);
endmodule
bind lmb_top lmb_top_sva u_sva (.*);
`default_nettype wire

// *** test/lmb_ctl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module lmb_ctl_model (
    input wire logic hclk,
    input wire logic ctl_gnt,
    input wire lmb_pkg::lmb_byte_t ctl_rdata,
    output logic [1:0] ctl_id,
    output logic ctl_req,
    output logic ctl_we,
    output logic ctl_buf,
    output lmb_pkg::lmb_byte_t ctl_wdata,
    output logic ctl_start,
    output logic ctl_tx_done,
    output logic ctl_rx_eot
);
    import lmb_pkg::*;
    initial begin
        ctl_id = 2'h0;
        ctl_req = 1'b0;
        ctl_we = 1'b0;
        ctl_buf = 1'b0;
        ctl_wdata = 8'h5a;
        {ctl_start, ctl_tx_done, ctl_rx_eot} = 3'h0;
    end
    // byte access either way, g tells whether it was granted
    task automatic acc(input logic [1:0] id, input logic w, input logic b, input lmb_byte_t d,
                       output lmb_byte_t q, output logic g);
        int n;
        @(posedge hclk);
        ctl_id <= id;
        ctl_req <= 1'b1;
        ctl_we <= w;
        ctl_buf <= b;
        ctl_wdata <= d;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (ctl_gnt !== 1'b1 && n < 20);
        g = (ctl_gnt === 1'b1);
        ctl_req <= 1'b0;
        // back to controller 0, which the pulses speak for
        ctl_id <= 2'h0;
        ctl_wdata <= ~d;
        @(posedge hclk);
        q = ctl_rdata;
    endtask
    task automatic pulse(input int k, input logic b);
        @(posedge hclk);
        ctl_buf <= b;
        ctl_start <= (k == 0);
        ctl_tx_done <= (k == 1);
        ctl_rx_eot <= (k == 2);
        @(posedge hclk);
        {ctl_start, ctl_tx_done, ctl_rx_eot} <= 3'h0;
    endtask
endmodule
`default_nettype wire

// *** test/lmb_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module lmb_top_tb;
    import lmb_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ctl_req, ctl_we, ctl_buf, ctl_gnt, ctl_rvalid;
    logic ctl_start, ctl_tx_done, ctl_rx_eot, tx_buffer_free_flag, rx_buffer_pointer_flag;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [31:0] seed = 32'h4a;
    logic [1:0] htrans, ctl_id;
    logic [2:0] hsize;
    lmb_byte_t ctl_wdata, ctl_rdata, q;
    lmb_byte_t exp_q [96];
    wire logic hready = hreadyout;
    int fail_count = 0;
    int samples_checked = 0;
    int b, i;
    lmb_top DUT (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .ctl_id(ctl_id),
        .ctl_req(ctl_req),
        .ctl_we(ctl_we),
        .ctl_buf(ctl_buf),
        .ctl_wdata(ctl_wdata),
        .ctl_gnt(ctl_gnt),
        .ctl_rdata(ctl_rdata),
        .ctl_rvalid(ctl_rvalid),
        .ctl_start(ctl_start),
        .ctl_tx_done(ctl_tx_done),
        .ctl_rx_eot(ctl_rx_eot),
        .tx_buffer_free_flag(tx_buffer_free_flag),
        .rx_buffer_pointer_flag(rx_buffer_pointer_flag)
    );
    lmb_ctl_model M (
        .hclk(hclk),
        .ctl_gnt(ctl_gnt),
        .ctl_rdata(ctl_rdata),
        .ctl_id(ctl_id),
        .ctl_req(ctl_req),
        .ctl_we(ctl_we),
        .ctl_buf(ctl_buf),
        .ctl_wdata(ctl_wdata),
        .ctl_start(ctl_start),
        .ctl_tx_done(ctl_tx_done),
        .ctl_rx_eot(ctl_rx_eot)
    );
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [31:0] pa(input int k);
        return (k != 0) ? 32'h1c00 : 32'h1800;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic cacc(input logic [1:0] id, input logic w, input logic b, input lmb_byte_t d, input logic want);
        logic g;
        M.acc(id, w, b, d, q, g);
        chk({31'h0, g}, {31'h0, want});
        if (g !== want)
            test_done();
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hready !== 1'b1 && n < 20);
            chk({31'h0, n < 20}, 32'h1);
            if (n >= 20)
                test_done();
            htrans <= 2'h0;
            hwdata <= d;
        end
        r = hrdata;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        chk(hrdata, 32'h0);
        chk({30'h0, hreadyout, ctl_rvalid}, 32'h2);
        chk({30'h0, tx_buffer_free_flag, rx_buffer_pointer_flag}, 32'h0);
        for (b = 0; b < 2; b++) begin
            for (i = 0; i < 96; i++) begin
                seed = xs(seed);
                exp_q[i] = seed[7:0];
                bus(1'b1, pa(b), seed);
            end
            for (i = 0; i < 96; i++) begin
                bus(1'b0, pa(b), 32'h0);
                chk(r, {24'h0, exp_q[i]});
            end
        end
        for (i = 0; i < 5; i++) begin
            seed = xs(seed);
            exp_q[i] = seed[7:0];
            cacc(2'h0, 1'b1, 1'b1, exp_q[i], 1'b1);
        end
        M.pulse(2, 1'b1);
        bus(1'b0, 32'h480, 32'h0);
        chk(r & 32'hc0, 32'h40);
        chk({31'h0, rx_buffer_pointer_flag}, 32'h1);
        for (i = 0; i < 5; i++) begin
            bus(1'b0, pa(1), 32'h0);
            chk(r, {24'h0, exp_q[i]});
        end
        bus(1'b1, 32'h46c, 32'h1);
        bus(1'b0, 32'h480, 32'h0);
        chk(r & 32'hc0, 32'h0);
        cacc(2'h0, 1'b0, 1'b0, 8'h00, 1'b0);
        cacc(2'h1, 1'b0, 1'b0, 8'h00, 1'b1);
        bus(1'b1, 32'h46c, 32'h0);
        bus(1'b1, 32'h46c, 32'h3);
        bus(1'b0, 32'h46c, 32'h0);
        chk(r, 32'h0);
        bus(1'b0, 32'h480, 32'h0);
        chk(r & 32'hc0, 32'h40);
        b = int'(r[7]);
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            exp_q[i] = seed[7:0];
            bus(1'b1, pa(b), seed);
        end
        M.pulse(0, b[0]);
        for (i = 0; i < 4; i++) begin
            cacc(2'h0, 1'b0, b[0], 8'h00, 1'b1);
            chk({24'h0, q}, {24'h0, exp_q[i]});
        end
        M.pulse(1, b[0]);
        bus(1'b0, pa(b), 32'h0);
        chk(r, 32'h0);
        chk({31'h0, tx_buffer_free_flag}, b);
        M.pulse(1, 1'b1);
        bus(1'b0, 32'h480, 32'h0);
        chk(r & 32'hc0, 32'hc0);
        chk({31'h0, tx_buffer_free_flag}, 32'h1);
        bus(1'b0, pa(1), 32'h0);
        chk(r, 32'h0);
        bus(1'b0, 32'h4000, 32'h0);
        chk(r, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
